// ---- nvm_command_pkg.sv ----
/*
 * constants for the command-issue front end of the memory controller.
 * assumes a 16-bit control register at offset 0x0 on a byte-addressed peripheral bus.
 */
package nvm_command_pkg;
	localparam logic [7:0]  ctrl_offset       = 8'h00;
	localparam logic [7:0]  exec_key          = 8'ha5;
	localparam logic [15:0] ctrl_reset        = 16'h0000;
	localparam int          key_lsb           = 8;
	localparam int          key_msb           = 15;
	localparam int          cmd_msb           = 6;
	localparam int          cmd_width         = 7;
	localparam logic [7:0]  status_offset     = 8'h04;
	localparam logic [7:0]  addr_offset       = 8'h08;
	localparam logic [7:0]  flags_offset      = 8'h0c;
	localparam int          ready_bit         = 0;
	localparam int          error_bit         = 1;
	localparam int          enable_bit        = 0;
	localparam int          addr_width        = 16;
	localparam int          hist_depth        = 8;
	localparam int          hist_addr_width   = 3;
endpackage : nvm_command_pkg

// ---- command_history_mem.sv ----
/*
 * small memory holding the last accepted commands, registered read data.
 * assumes a single clock; write and read in any cycle.
 */
`timescale 1ns/10ps
module command_history_mem #(
	parameter int width      = 7,
	parameter int depth      = 8,
	parameter int addr_width = 3
) (
	// clock
	input  wire logic                  sys_clk,
	// write side
	input  wire logic                  wr_en,
	input  wire logic [addr_width-1:0] wr_addr,
	input  wire logic [width-1:0]      wr_data,
	// read side
	input  wire logic [addr_width-1:0] rd_addr,
	output logic      [width-1:0]      rd_data
);
	initial begin
		if (depth > (1 << addr_width)) begin
			$error("depth too large for addr_width");
		end
	end

	logic [width-1:0] mem [depth];

	always_ff @(posedge sys_clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end
endmodule : command_history_mem

// ---- nvm_command_issue.sv ----
/*
 * command-issue front end: key check, error flag, arbitration with memory-bus traffic.
 * assumes one 125 MHz clock, a byte-addressed 32-bit peripheral bus with byte strobes,
 * and a memory block that reports busy and pulses done when a command finishes.
 */
`timescale 1ns/10ps
module nvm_command_issue #(
	parameter int cmd_width  = nvm_command_pkg::cmd_width,
	parameter int addr_width = nvm_command_pkg::addr_width
) (
	// clock and reset
	input  wire logic                  sys_clk,
	input  wire logic                  reset_n,
	// peripheral register bus
	input  wire logic                  bus_sel,
	input  wire logic                  bus_write,
	input  wire logic [7:0]            bus_addr,
	input  wire logic [3:0]            bus_strb,
	input  wire logic [31:0]           bus_wdata,
	output logic      [31:0]           bus_rdata,
	// memory bus and memory block
	input  wire logic                  mem_bus_active,
	input  wire logic                  mem_block_busy,
	input  wire logic                  mem_cmd_done,
	// command issued to the memory block
	output logic                       cmd_start,
	output logic      [cmd_width-1:0]  cmd_code,
	output logic      [addr_width:0]   cmd_byte_addr
);
	initial begin
		if (cmd_width != nvm_command_pkg::cmd_width) begin
			$error("command field is fixed at 7 bits");
		end
		if (addr_width < 1 || addr_width > 16) begin
			$error("addr_width out of range");
		end
	end

	typedef enum logic [1:0] {st_idle, st_pending, st_running} issue_state_e;

	// ----------------------------------------------------------------
	// byte-lane merge
	// ----------------------------------------------------------------
	function automatic logic [15:0] merge16(input logic [15:0] old_v,
	                                        input logic [15:0] new_v,
	                                        input logic [1:0]  strb);
		merge16 = {strb[1] ? new_v[15:8] : old_v[15:8],
		           strb[0] ? new_v[7:0]  : old_v[7:0]};
	endfunction : merge16

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	logic                  busy;
	issue_state_e          state_q;
	issue_state_e          state_d;
	logic [cmd_width-1:0]  cmd_q;
	logic [7:0]            key_q;
	logic                  issued_q;
	logic                  error_q;
	logic                  enable_q;
	logic [addr_width-1:0] addr_q;
	logic [nvm_command_pkg::hist_addr_width-1:0] hist_wr_q;
	logic [cmd_width-1:0]  hist_rd;
	logic [31:0]           rdata_q;
	logic [15:0]           ctrl_view;

	wire wr        = bus_sel && bus_write;
	wire ctrl_hit  = bus_addr == nvm_command_pkg::ctrl_offset;
	wire stat_hit  = bus_addr == nvm_command_pkg::status_offset;
	wire addr_hit  = bus_addr == nvm_command_pkg::addr_offset;
	wire flag_hit  = bus_addr == nvm_command_pkg::flags_offset;
	wire ctrl_wr   = wr && ctrl_hit && (bus_strb[1:0] != 2'h0);
	// key and command must arrive in one access, so both lanes are needed
	wire full_wr   = ctrl_wr && (bus_strb[1:0] == 2'h3);
	wire key_ok    = full_wr && (bus_wdata[nvm_command_pkg::key_msb:
	                           nvm_command_pkg::key_lsb] == nvm_command_pkg::exec_key);
	wire key_bad   = ctrl_wr && !key_ok;
	assign busy    = state_q != st_idle;
	wire accept    = key_ok && !busy;
	wire collide   = key_ok && busy;
	wire mem_idle  = !mem_bus_active && !mem_block_busy;
	wire ready     = !busy;

	wire [15:0] ctrl_new = merge16({key_q, 1'b0, cmd_q}, bus_wdata[15:0], bus_strb[1:0]);
	wire [15:0] addr_new = merge16(16'(addr_q), bus_wdata[15:0], bus_strb[1:0]);
	// a command accepted on an idle memory launches at the same edge cmd_q loads
	wire [cmd_width-1:0] launch_code = accept ? ctrl_new[nvm_command_pkg::cmd_msb:0] : cmd_q;

	// ----------------------------------------------------------------
	// issue state machine
	// ----------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		case (state_q)
			st_idle: begin
				if (accept) begin
					state_d = mem_idle ? st_running : st_pending;
				end
			end
			st_pending: begin
				if (mem_idle) begin
					state_d = st_running;
				end
			end
			st_running: begin
				if (mem_cmd_done) begin
					state_d = st_idle;
				end
			end
			default: state_d = st_idle;
		endcase
	end

	wire start_now = (state_q != st_running) && (state_d == st_running);

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= st_idle;
		end else begin
			state_q <= state_d;
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			cmd_q    <= nvm_command_pkg::ctrl_reset[cmd_width-1:0];
			key_q    <= nvm_command_pkg::ctrl_reset[nvm_command_pkg::key_msb:
			                                        nvm_command_pkg::key_lsb];
			issued_q <= 1'b0;
			error_q  <= 1'b0;
			enable_q <= 1'b0;
			addr_q   <= '0;
		end else begin
			if (accept) begin
				cmd_q    <= ctrl_new[nvm_command_pkg::cmd_msb:0];
				key_q    <= ctrl_new[nvm_command_pkg::key_msb:nvm_command_pkg::key_lsb];
				issued_q <= 1'b1;
			end
			// set wins over a write-one clear in the same cycle
			if (key_bad || collide) begin
				error_q <= 1'b1;
			end else if (wr && stat_hit && bus_strb[0] &&
			             bus_wdata[nvm_command_pkg::error_bit]) begin
				error_q <= 1'b0;
			end
			if (wr && stat_hit && bus_strb[0]) begin
				enable_q <= bus_wdata[nvm_command_pkg::enable_bit];
			end
			if (wr && addr_hit && !enable_q && !busy) begin
				addr_q <= addr_new[addr_width-1:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// history of accepted commands
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			hist_wr_q <= '0;
		end else if (accept) begin
			hist_wr_q <= hist_wr_q + 1'b1;
		end
	end

	command_history_mem #(
		.width      (cmd_width),
		.depth      (nvm_command_pkg::hist_depth),
		.addr_width (nvm_command_pkg::hist_addr_width)
	) u_hist (
		.sys_clk (sys_clk),
		.wr_en   (accept),
		.wr_addr (hist_wr_q),
		.wr_data (ctrl_new[nvm_command_pkg::cmd_msb:0]),
		.rd_addr (hist_wr_q - 1'b1),
		.rd_data (hist_rd)
	);

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	assign ctrl_view = {key_q[7:1], key_q[0] | !issued_q, 1'b0, cmd_q};
	// history memory is not reset, so hide it until a command was accepted
	wire [cmd_width-1:0] last_cmd = issued_q ? hist_rd : '0;

	wire [31:0] rd_mux =
		ctrl_hit ? {16'h0000, ctrl_view} :
		stat_hit ? {16'h0000, last_cmd, 7'h00, error_q, enable_q} :
		addr_hit ? {{(32-addr_width){1'b0}}, addr_q} :
		flag_hit ? {31'h00000000, ready} :
		32'h00000000;

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rdata_q <= 32'h00000000;
		end else if (bus_sel && !bus_write) begin
			rdata_q <= rd_mux;
		end
	end

	assign bus_rdata = rdata_q;

	// ----------------------------------------------------------------
	// command outputs
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			cmd_start     <= 1'b0;
			cmd_code      <= '0;
			cmd_byte_addr <= '0;
		end else begin
			cmd_start <= start_now;
			if (start_now) begin
				cmd_code      <= launch_code;
				cmd_byte_addr <= {addr_q, 1'b0};
			end
		end
	end
endmodule : nvm_command_issue

// ---- nvm_command_issue_properties.sv ----
/* concurrent checks for the command-issue front end.
 * assumes binding to nvm_command_issue; memory block pulses done only after a start. */
`timescale 1ns/10ps
module nvm_command_issue_properties #(
	parameter int cmd_width  = 7,
	parameter int addr_width = 16
) (
	// clock and reset
	input wire logic                  sys_clk,
	input wire logic                  reset_n,
	// register bus
	input wire logic                  bus_sel,
	input wire logic                  bus_write,
	input wire logic [7:0]            bus_addr,
	input wire logic [3:0]            bus_strb,
	input wire logic [31:0]           bus_wdata,
	input wire logic [31:0]           bus_rdata,
	// memory side
	input wire logic                  mem_bus_active,
	input wire logic                  mem_block_busy,
	input wire logic                  mem_cmd_done,
	input wire logic                  cmd_start,
	input wire logic [cmd_width-1:0]  cmd_code,
	input wire logic [addr_width:0]   cmd_byte_addr
);
	// ------------------------------------------------------------
	// helper state
	// ------------------------------------------------------------
	logic active_q, run_q, seen_q;
	wire logic ctl_wr = bus_sel && bus_write && bus_addr == nvm_command_pkg::ctrl_offset
		&& bus_strb[1:0] == 2'h3;
	wire logic good_key = ctl_wr && bus_wdata[15:8] == nvm_command_pkg::exec_key;
	wire logic bad_key = ctl_wr && bus_wdata[15:8] != nvm_command_pkg::exec_key;
	wire logic idle = !mem_bus_active && !mem_block_busy;
	wire logic rd_any = bus_sel && !bus_write;
	logic        en_q;
	logic [15:0] am_q;
	wire logic st_wr = bus_sel && bus_write && bus_addr == nvm_command_pkg::status_offset
		&& bus_strb[0];
	wire logic ad_wr = bus_sel && bus_write && bus_addr == nvm_command_pkg::addr_offset
		&& !en_q && !active_q;
	wire logic [addr_width:0] exp_baddr = {am_q[addr_width-1:0], 1'b0};
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			en_q <= 1'b0;
			am_q <= 16'h0000;
		end else begin
			if (st_wr) begin
				en_q <= bus_wdata[nvm_command_pkg::enable_bit];
			end
			if (ad_wr && bus_strb[0]) begin
				am_q[7:0] <= bus_wdata[7:0];
			end
			if (ad_wr && bus_strb[1]) begin
				am_q[15:8] <= bus_wdata[15:8];
			end
		end
	end
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			active_q <= 1'b0;
			run_q    <= 1'b0;
			seen_q   <= 1'b0;
		end else begin
			active_q <= (good_key && !active_q) || (active_q && !mem_cmd_done);
			run_q    <= cmd_start || (run_q && !mem_cmd_done);
			seen_q   <= seen_q || (good_key && !active_q);
		end
	end
	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	sequence accept_s; good_key && !active_q && idle; endsequence
	sequence launch_s; cmd_start && cmd_code == $past(bus_wdata[cmd_width-1:0]); endsequence
	chk_key_launch: assert property (accept_s |=> launch_s)
		else $error("accepted command did not launch");
	chk_bad_key: assert property (bad_key && !active_q |=> !cmd_start)
		else $error("wrong key launched a command");
	chk_busy_refuse: assert property (good_key && run_q |=> !cmd_start)
		else $error("command launched while another runs");
	chk_wait_idle: assert property (cmd_start |-> $past(idle))
		else $error("launch while memory side busy");
	chk_key_bit: assert property (rd_any && bus_addr == 8'h00 && !seen_q |=> bus_rdata[8])
		else $error("key bit zero not one before first command");
	chk_unit_addr: assert property (cmd_start |-> cmd_byte_addr == exp_baddr)
		else $error("byte address not twice the unit address");
	chk_code_hold: assert property (!cmd_start |-> $stable(cmd_code))
		else $error("command code moved without launch");
	chk_ready_flag: assert property (rd_any && bus_addr == 8'h0c |=> bus_rdata[0] == !$past(active_q))
		else $error("ready flag wrong");
endmodule : nvm_command_issue_properties

// ---- mem_block_model.sv ----
/* memory block model: busy for lat+1 cycles after a launch, then a done pulse.
 * assumes one clock shared with the front end. */
`timescale 1ns/10ps
module mem_block_model (
	// clock and reset
	input wire logic       sys_clk,
	input wire logic       reset_n,
	// command side
	input wire logic       cmd_start,
	input wire logic [3:0] lat,
	output logic           mem_block_busy,
	output logic           mem_cmd_done
);
	logic [3:0] cnt_q;
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_q          <= 4'h0;
			mem_block_busy <= 1'b0;
			mem_cmd_done   <= 1'b0;
		end else begin
			mem_cmd_done <= mem_block_busy && cnt_q == 4'h0;
			if (cmd_start) begin
				mem_block_busy <= 1'b1;
				cnt_q          <= lat;
			end else if (mem_block_busy) begin
				mem_block_busy <= cnt_q != 4'h0;
				cnt_q          <= cnt_q - 4'h1;
			end
		end
	end
endmodule : mem_block_model

// ---- nvm_command_issue_tb.sv ----
/* self-checking bench for the command-issue front end.
 * assumes nvm_command_pkg, the memory block model and the checker are compiled first. */
`timescale 1ns/10ps
module nvm_command_issue_tb;
	logic        sys_clk = 1'b0, reset_n = 1'b0, bus_sel = 1'b0, bus_write = 1'b0;
	logic        mem_bus_active = 1'b0;
	logic [7:0]  bus_addr = 8'h00;
	logic [3:0]  bus_strb = 4'h0, lat = 4'h3;
	logic [31:0] bus_wdata = 32'h0, rv;
	wire logic [31:0] bus_rdata;
	wire logic        mem_block_busy, mem_cmd_done, cmd_start;
	wire logic [6:0]  cmd_code;
	wire logic [16:0] cmd_byte_addr;
	int failures = 0, n_compared = 0;
	always #4 sys_clk = ~sys_clk;
	nvm_command_issue dut_u (.sys_clk, .reset_n, .bus_sel, .bus_write, .bus_addr, .bus_strb,
		.bus_wdata, .bus_rdata, .mem_bus_active, .mem_block_busy, .mem_cmd_done, .cmd_start,
		.cmd_code, .cmd_byte_addr);
	mem_block_model mem_u (.sys_clk, .reset_n, .cmd_start, .lat, .mem_block_busy, .mem_cmd_done);
	// ------------------------------------------------------------
	// bus and check tasks
	// ------------------------------------------------------------
	task automatic wrap_up;
		if (failures == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : wrap_up
	task automatic chk(input string what, input logic [31:0] exp, got);
		n_compared++;
		if (got !== exp) begin
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
			failures++;
		end
	endtask : chk
	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
	                   input logic [3:0] s);
		@(posedge sys_clk);
		bus_sel   <= 1'b1;
		bus_write <= w;
		bus_addr  <= a;
		bus_wdata <= d;
		bus_strb  <= s;
		@(posedge sys_clk);
		bus_sel   <= 1'b0;
		bus_write <= 1'b0;
		#1 rv = bus_rdata;
	endtask : acc
	task automatic issue(input logic [6:0] c, input logic [7:0] k = 8'ha5);
		acc(1'b1, 8'h00, {16'h0, k, 1'b0, c}, 4'h3);
	endtask : issue
	task automatic wait_ready;
		for (int i = 0; i < 40; i++) begin
			acc(1'b0, 8'h0c, 32'h0, 4'h0);
			if (rv === 32'h1) begin
				return;
			end
		end
		chk("ready timeout", 32'h1, rv);
		wrap_up();
	endtask : wait_ready
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset;
		acc(1'b0, 8'h00, 32'h0, 4'h0);
		chk("ctrl after reset", 32'h100, rv);
		acc(1'b0, 8'h0c, 32'h0, 4'h0);
		chk("ready after reset", 32'h1, rv);
		acc(1'b0, 8'h04, 32'h0, 4'h0);
		chk("status after reset", 32'h0, rv);
		acc(1'b0, 8'h10, 32'h0, 4'h0);
		chk("unmapped read", 32'h0, rv);
	endtask : t_reset
	task automatic t_launch;
		acc(1'b1, 8'h08, 32'h12, 4'h3);
		issue(7'h05);
		chk("start", 32'h1, cmd_start);
		chk("code", 32'h5, cmd_code);
		chk("byte addr", 32'h24, cmd_byte_addr);
		acc(1'b0, 8'h0c, 32'h0, 4'h0);
		chk("ready busy", 32'h0, rv);
		wait_ready();
	endtask : t_launch
	task automatic t_bad_key;
		issue(7'h07, 8'h5a);
		chk("no start", 32'h0, cmd_start);
		acc(1'b0, 8'h04, 32'h0, 4'h0);
		chk("error set", 32'ha02, rv);
		acc(1'b1, 8'h04, 32'h2, 4'h1);
		acc(1'b0, 8'h04, 32'h0, 4'h0);
		chk("error cleared", 32'ha00, rv);
	endtask : t_bad_key
	task automatic t_busy;
		@(posedge sys_clk) lat <= 4'hc;
		issue(7'h11);
		issue(7'h22);
		chk("second start", 32'h0, cmd_start);
		acc(1'b0, 8'h04, 32'h0, 4'h0);
		chk("busy error", 32'h2202, rv);
		acc(1'b1, 8'h04, 32'h2, 4'h1);
		wait_ready();
	endtask : t_busy
	task automatic t_arb;
		@(posedge sys_clk) mem_bus_active <= 1'b1;
		lat <= 4'h1;
		issue(7'h33);
		repeat (3) begin
			chk("deferred", 32'h0, cmd_start);
			@(posedge sys_clk) #1;
		end
		@(posedge sys_clk) mem_bus_active <= 1'b0;
		for (int i = 0; i < 4 && cmd_start !== 1'b1; i++) @(posedge sys_clk) #1;
		chk("late start", 32'h1, cmd_start);
		chk("late code", 32'h33, cmd_code);
		wait_ready();
	endtask : t_arb
	task automatic t_protect;
		acc(1'b1, 8'h04, 32'h1, 4'h1);
		acc(1'b1, 8'h08, 32'h34, 4'h3);
		acc(1'b0, 8'h08, 32'h0, 4'h0);
		chk("addr kept", 32'h12, rv);
		acc(1'b1, 8'h04, 32'h0, 4'h1);
	endtask : t_protect
	initial begin
		repeat (16) @(posedge sys_clk);
		reset_n <= 1'b1;
		t_reset();
		t_launch();
		t_bad_key();
		t_busy();
		t_arb();
		t_protect();
		wrap_up();
	end
endmodule : nvm_command_issue_tb
bind nvm_command_issue nvm_command_issue_properties #(.cmd_width(cmd_width),
	.addr_width(addr_width)) chk_u (.sys_clk, .reset_n, .bus_sel, .bus_write, .bus_addr,
	.bus_strb, .bus_wdata, .bus_rdata, .mem_bus_active, .mem_block_busy, .mem_cmd_done,
	.cmd_start, .cmd_code, .cmd_byte_addr);
